// [bench/mssr_dev_model.sv]
// Behavioural model of the device maintenance registers
`timescale 1ns/1ps
`default_nettype none
module mssr_dev_model
	import mssr_pkg::*;
#(
	// Populated channels; either one may be the only one
	parameter logic [1:0] CHAN_USED = 2'b10
)
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Register port
	input wire logic dev_wr_q,
	input wire logic [mssr_pkg::AW-1:0] dev_addr_q,
	input wire logic [mssr_pkg::DW-1:0] dev_wdata_q,
	input wire logic [mssr_pkg::DW-1:0] dev_wmask_q,
	input wire logic [3:0] ack_wait,
	input wire logic slow_mode,
	output logic dev_ack,
	// Register contents and activity
	output logic [mssr_pkg::DW-1:0] regs_q [4],
	output logic scrubbing,
	output logic refresh_on,
	output logic [15:0] ref_cmds_q,
	output logic [31:0] scrub_line_q
);
	// ------------------------------------------------------------
	// Registers and acknowledge
	// ------------------------------------------------------------
	logic [3:0] cnt_q;
	logic scrub_on_q;

	// Acknowledge after a chosen wait, so slow answers are exercised
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			dev_ack <= 1'b0;
			cnt_q <= 4'h0;
			scrub_on_q <= 1'b0;
			regs_q <= '{64'h0, {13'h200, 51'h0}, 64'h0, 64'h0};
		end else begin
			dev_ack <= 1'b0;
			if (dev_wr_q && !dev_ack) begin
				cnt_q <= cnt_q + 4'h1;
				if (cnt_q >= ack_wait) begin
					dev_ack <= 1'b1;
					cnt_q <= 4'h0;
				end
			end
			if (dev_wr_q && dev_ack) begin
				regs_q[dev_addr_q[4:3]] <= (regs_q[dev_addr_q[4:3]] &
					~dev_wmask_q) | (dev_wdata_q & dev_wmask_q);
				// Only a zero-to-one change of begin-scrub starts it
				if (dev_addr_q == OFS_EXEC && dev_wdata_q[61] &&
					!regs_q[0][61]) scrub_on_q <= 1'b1;
			end
		end
	end

	// Block bits gate scrubs and refreshes
	assign scrubbing = scrub_on_q && !regs_q[0][59];
	assign refresh_on = regs_q[0][62] && !regs_q[0][60];

	// ------------------------------------------------------------
	// Maintenance timers; clk_sys stands in for the memory clock
	// ------------------------------------------------------------
	logic [1:0] div_q;
	logic [12:0] tick_q;
	logic [12:0] ref_q;
	logic [15:0] scb_q;
	logic [6:0] gap_q;
	logic pend_q;
	wire logic div_en = div_q == 2'h3;
	wire logic tick_en = div_en && tick_q >= regs_q[2][63:51];
	wire logic ref_due = div_en && refresh_on
		&& ref_q >= regs_q[1][63:51];

	// Up-counters meet a new load at once instead of after the old count
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			div_q <= 2'h0;
			tick_q <= 13'h0;
			ref_q <= 13'h0;
			scb_q <= 16'h0;
			gap_q <= 7'h0;
			pend_q <= 1'b0;
			ref_cmds_q <= 16'h0;
			scrub_line_q <= 32'h0;
		end else begin
			div_q <= div_q + 2'h1;
			if (div_en)
				tick_q <= tick_en ? 13'h0 : tick_q + 13'h1;
			if (!refresh_on)
				ref_q <= 13'h0;
			else if (div_en)
				ref_q <= ref_due ? 13'h0 : ref_q + 13'h1;
			if (div_en && gap_q != 7'h0)
				gap_q <= gap_q - 7'h1;
			// Slow mode spaces commands; a due refresh waits its turn
			if (div_en && (ref_due || (pend_q && refresh_on))
				&& (!slow_mode || gap_q == 7'h0)) begin
				pend_q <= 1'b0;
				gap_q <= 7'h44;
				// One row of one bank per command and channel
				ref_cmds_q <= ref_cmds_q + 16'(CHAN_USED[0])
					+ 16'(CHAN_USED[1]);
			end else if (ref_due) begin
				pend_q <= 1'b1;
			end
			// Each scrub reads the next 128-byte line; no error, no write
			if (tick_en && scrubbing) begin
				if (scb_q >= regs_q[1][50:35]) begin
					scb_q <= 16'h0;
					scrub_line_q <= scrub_line_q + 32'h80;
				end else begin
					scb_q <= scb_q + 16'h1;
				end
			end
		end
	end
endmodule : mssr_dev_model
`default_nettype wire

// [bench/mssr_maint_sva.sv]
// Property checker for the maintenance set-up host
`timescale 1ns/1ps
`default_nettype none
module mssr_maint_sva
	import mssr_pkg::*;
(
	// Clock, reset and orders
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [11:0] mem_clk_mhz,
	input wire logic [16:0] scrub_ticks,
	input wire logic [13:0] refresh_cycles,
	input wire logic [7:0] rd_row_cycle,
	input wire logic [7:0] wr_row_cycle,
	input wire logic slow_mode,
	input wire logic [1:0] subpage_mode,
	input wire logic functional_reads_done,
	input wire logic retain_contents,
	input wire logic self_refresh,
	// Device register port
	input wire logic dev_wr_q,
	input wire logic [mssr_pkg::AW-1:0] dev_addr_q,
	input wire logic [mssr_pkg::DW-1:0] dev_wdata_q,
	input wire logic [mssr_pkg::DW-1:0] dev_wmask_q,
	input wire logic dev_ack
);
	// ------------------------------------------------------------
	// Expected loads
	// ------------------------------------------------------------
	logic [8:0] row;
	logic [15:0] flr, pace, ref_exp, scb_exp, tick_exp;
	logic begun_q, reads_q;
	wire logic wr_ref = dev_wr_q && dev_addr_q == OFS_REFSCB;
	wire logic wr_exe = dev_wr_q && dev_addr_q == OFS_EXEC;

	// Loads rebuilt from the orders, saturated the same way
	always_comb begin
		row = (rd_row_cycle + 9'h4 > wr_row_cycle + 9'h1) ?
			rd_row_cycle + 9'h4 : wr_row_cycle + 9'h1;
		flr = ((16'h5 * row + 16'h1) >> 1) - 16'h1;
		pace = (slow_mode && flr < 16'h68) ? 16'h68 : flr;
		ref_exp = (16'(refresh_cycles) >> subpage_mode) - 16'h1;
		if (ref_exp > 16'h1869) ref_exp = 16'h1869;
		if (ref_exp < pace) ref_exp = pace;
		if (scrub_ticks == 17'h0) scb_exp = 16'h0;
		else if (scrub_ticks > 17'h80b6) scb_exp = 16'h80b5;
		else scb_exp = 16'(scrub_ticks - 17'h1);
		tick_exp = 16'(mem_clk_mhz) * 16'ha / 16'h4 - 16'h1;
		if (tick_exp > 16'h1fff) tick_exp = 16'h1fff;
	end

	// History since reset: begin-scrub written, reads seen
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			begun_q <= 1'b0;
			reads_q <= 1'b0;
		end else begin
			begun_q <= begun_q | (wr_exe & dev_ack & dev_wmask_q[61]);
			reads_q <= reads_q | functional_reads_done;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	a_scrub_field: assert property (wr_ref |->
		dev_wdata_q[50:35] == scb_exp) else $error("scrub load wrong");
	a_scrub_max: assert property (wr_ref |->
		dev_wdata_q[50:35] <= SCB_LOAD_MAX) else $error("scrub load high");
	a_begin_once: assert property (wr_exe && dev_wmask_q[61] |->
		!begun_q) else $error("begin scrub written twice");
	a_begin_after_reads: assert property (wr_exe && dev_wmask_q[61]
		|-> reads_q) else $error("scrub begun before reads");
	a_tick_load: assert property (dev_wr_q && dev_addr_q == OFS_TICK
		&& mem_clk_mhz != 12'h0 |-> dev_wdata_q[63:51] == tick_exp[12:0])
		else $error("tick load wrong");
	a_ref_floor: assert property (wr_ref |->
		dev_wdata_q[63:51] >= flr[12:0]) else $error("refresh below floor");
	a_ref_slow: assert property (wr_ref && slow_mode |->
		dev_wdata_q[63:51] > 13'h67) else $error("slow refresh too low");
	a_ref_max: assert property (wr_ref |->
		dev_wdata_q[63:51] <= REF_LOAD_MAX) else $error("refresh load high");
	a_ref_subpage: assert property (wr_ref && subpage_mode != 2'h3 &&
		(refresh_cycles >> subpage_mode) != 14'h0 |->
		dev_wdata_q[63:51] == ref_exp[12:0]) else $error("refresh load wrong");
	a_ref_keep: assert property (wr_exe && dev_wdata_q[60] |->
		!retain_contents || self_refresh) else $error("refresh stopped");
endmodule : mssr_maint_sva

bind mssr_maint_host mssr_maint_sva mssr_maint_sva_inst (.clk_sys, .reset,
	.mem_clk_mhz, .scrub_ticks, .refresh_cycles, .rd_row_cycle,
	.wr_row_cycle, .slow_mode, .subpage_mode, .functional_reads_done,
	.retain_contents, .self_refresh, .dev_wr_q, .dev_addr_q, .dev_wdata_q,
	.dev_wmask_q, .dev_ack);
`default_nettype wire

// [bench/testbench.sv]
// Self-checking bench for the maintenance set-up host
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import mssr_pkg::*;
	// ------------------------------------------------------------
	// Stimulus, observation and instances
	// ------------------------------------------------------------
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic cfg_start = 1'b0, slow_mode = 1'b0, write_mask_en = 1'b0;
	logic scrub_en = 1'b0, functional_reads_done = 1'b0, scrub_hold = 1'b0;
	logic refresh_off = 1'b0, retain_contents = 1'b0, self_refresh = 1'b0;
	logic [11:0] mem_clk_mhz = 12'h0;
	logic [16:0] scrub_ticks = 17'h0;
	logic [13:0] refresh_cycles = 14'h0;
	logic [7:0] rd_row_cycle = 8'h0, wr_row_cycle = 8'h0;
	logic [1:0] subpage_mode = 2'h0;
	logic [3:0] ack_wait = 4'h0;
	logic busy_q, cfg_done_q, scrub_running_q, refresh_running_q;
	logic scrub_clamped_q, refresh_clamped_q, dev_wr_q, dev_ack;
	logic scrubbing, refresh_on;
	logic [15:0] ref_cmds_q;
	logic [31:0] scrub_line_q, mark;
	logic [AW-1:0] dev_addr_q;
	logic [DW-1:0] dev_wdata_q, dev_wmask_q;
	logic [DW-1:0] regs_q [4];
	int bad_count = 0;
	int samples_checked = 0;

	always #10 clk_sys = ~clk_sys;

	mssr_maint_host mssr_maint_host_inst (.clk_sys, .reset, .cfg_start,
		.mem_clk_mhz, .scrub_ticks, .refresh_cycles, .rd_row_cycle,
		.wr_row_cycle, .slow_mode, .subpage_mode, .write_mask_en, .scrub_en,
		.functional_reads_done, .scrub_hold, .refresh_off,
		.retain_contents, .self_refresh, .busy_q, .cfg_done_q,
		.scrub_running_q, .refresh_running_q, .scrub_clamped_q,
		.refresh_clamped_q, .dev_wr_q, .dev_addr_q, .dev_wdata_q,
		.dev_wmask_q, .dev_ack);
	mssr_dev_model mssr_dev_model_inst (.clk_sys, .reset, .dev_wr_q,
		.dev_addr_q, .dev_wdata_q, .dev_wmask_q, .ack_wait, .dev_ack,
		.regs_q, .scrubbing, .refresh_on, .slow_mode, .ref_cmds_q,
		.scrub_line_q);

	task automatic give_verdict();
		if (bad_count == 0 && samples_checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : give_verdict

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Orders must settle three cycles before the start pulse
	task automatic cfg(input logic [11:0] m, input logic [16:0] t,
		input logic [13:0] c, input logic [7:0] r, input logic [7:0] w,
		input logic s, input logic [1:0] p);
		@(posedge clk_sys);
		mem_clk_mhz <= m;
		scrub_ticks <= t;
		refresh_cycles <= c;
		rd_row_cycle <= r;
		wr_row_cycle <= w;
		slow_mode <= s;
		subpage_mode <= p;
		repeat (3) @(posedge clk_sys);
		cfg_start <= 1'b1;
		@(posedge clk_sys);
		cfg_start <= 1'b0;
	endtask : cfg

	// Wait for the walk to end, then read back the device fields
	task automatic fin(input logic [12:0] et, input logic [12:0] er,
		input logic [15:0] es);
		int n;
		n = 0;
		do begin
			@(negedge clk_sys);
			n++;
		end while (cfg_done_q !== 1'b1 && n < 3000);
		if (n >= 3000) begin
			bad_count++;
			give_verdict();
		end
		chk(regs_q[2][63:51], et);
		chk(regs_q[1][63:51], er);
		chk(regs_q[1][50:35], es);
	endtask : fin

	task automatic wait_exec(input int b, input logic v);
		int n;
		n = 0;
		while (regs_q[0][b] !== v && n < 500) begin
			@(negedge clk_sys);
			n++;
		end
		chk(regs_q[0][b], v);
		if (n >= 500) give_verdict();
	endtask : wait_exec

	// Main sequence: set-ups with boundary loads, then run-time levels
	initial begin
		repeat (4) @(posedge clk_sys);
		reset <= 1'b0;
		@(negedge clk_sys);
		chk(regs_q[1][63:51], 13'h200);
		@(posedge clk_sys);
		scrub_en <= 1'b1;
		write_mask_en <= 1'b1;
		cfg(12'h5dc, 17'h80c, 14'hb7, 8'ha, 8'ha, 1'b0, 2'h0);
		repeat (100) @(negedge clk_sys);
		chk(busy_q, 1'b1);
		chk(regs_q[0][61], 1'b0);
		@(posedge clk_sys);
		functional_reads_done <= 1'b1;
		fin(13'hea5, 13'hb6, 16'h80b);
		chk(regs_q[3][60], 1'b1);
		chk(regs_q[0][62:59], 4'hc);
		chk({scrub_running_q, refresh_running_q, scrubbing, refresh_on},
			4'hf);
		@(posedge clk_sys);
		ack_wait <= 4'h5;
		cfg(12'h4b0, 17'h1ffff, 14'h3fff, 8'ha, 8'ha, 1'b0, 2'h0);
		fin(13'hbb7, 13'h1869, 16'h80b5);
		chk({scrub_clamped_q, refresh_clamped_q}, 2'h3);
		cfg(12'h5dc, 17'h1, 14'h32, 8'ha, 8'ha, 1'b1, 2'h0);
		fin(13'hea5, 13'h68, 16'h0);
		chk({scrub_clamped_q, refresh_clamped_q}, 2'h0);
		cfg(12'h5dc, 17'h80b6, 14'h320, 8'ha, 8'ha, 1'b0, 2'h2);
		fin(13'hea5, 13'hc7, 16'h80b5);
		cfg(12'h5dc, 17'h2, 14'h320, 8'ha, 8'ha, 1'b0, 2'h1);
		fin(13'hea5, 13'h18f, 16'h1);
		cfg(12'h5dc, 17'h3, 14'h64, 8'h64, 8'h0, 1'b0, 2'h0);
		fin(13'hea5, 13'h103, 16'h2);
		// A slow memory clock gives a 40-cycle tick to watch scrubs by
		cfg(12'h4, 17'h3, 14'h64, 8'h0, 8'hc8, 1'b0, 2'h0);
		fin(13'h9, 13'h1f6, 16'h2);
		chk(scrub_running_q, 1'b1);
		mark = scrub_line_q;
		repeat (360) @(negedge clk_sys);
		chk(scrub_line_q - mark, 32'h180);
		@(posedge clk_sys);
		scrub_hold <= 1'b1;
		wait_exec(59, 1'b1);
		chk(scrubbing, 1'b0);
		mark = scrub_line_q;
		repeat (240) @(negedge clk_sys);
		chk(scrub_line_q - mark, 32'h0);
		@(posedge clk_sys);
		scrub_hold <= 1'b0;
		wait_exec(59, 1'b0);
		@(posedge clk_sys);
		retain_contents <= 1'b1;
		refresh_off <= 1'b1;
		repeat (60) @(negedge clk_sys);
		chk(regs_q[0][60], 1'b0);
		@(posedge clk_sys);
		self_refresh <= 1'b1;
		wait_exec(60, 1'b1);
		chk(refresh_on, 1'b0);
		mark = 32'(ref_cmds_q);
		repeat (2100) @(negedge clk_sys);
		chk(32'(ref_cmds_q) - mark, 32'h0);
		chk(refresh_running_q, 1'b0);
		@(posedge clk_sys);
		refresh_off <= 1'b0;
		wait_exec(60, 1'b0);
		chk(refresh_on, 1'b1);
		repeat (2100) @(negedge clk_sys);
		chk(refresh_running_q, 1'b1);
		mark = 32'(ref_cmds_q);
		repeat (2012) @(negedge clk_sys);
		chk(32'(ref_cmds_q) - mark, 32'h1);
		give_verdict();
	end
endmodule : testbench
`default_nettype wire

// [verilog/mssr_load_calc.sv]
// Load value arithmetic with the software-side limits applied
`timescale 1ns/1ps
`default_nettype none
module mssr_load_calc
	import mssr_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Requested figures
	input wire logic [16:0] scrub_ticks,
	input wire logic [13:0] refresh_cycles,
	input wire logic [7:0] rd_row_cycle,
	input wire logic [7:0] wr_row_cycle,
	input wire logic slow_mode,
	input wire logic [1:0] subpage_mode,
	// Loads to program
	output logic [15:0] scrub_load_q,
	output logic [12:0] ref_load_q,
	output logic scrub_clamped_q,
	output logic ref_clamped_q
);
	logic [15:0] scrub_load_d;
	logic [12:0] ref_load_d;
	logic scrub_clamped_d;
	logic ref_clamped_d;

	// Interval minus one, floor and ceiling checks
	always_comb begin
		logic [16:0] sm1;
		logic [15:0] div;
		logic [15:0] ld;
		logic [15:0] m;
		logic [15:0] lo;
		sm1 = (scrub_ticks == 17'h0) ? 17'h0 : scrub_ticks - 17'h1;
		scrub_clamped_d = sm1 > {1'b0, SCB_LOAD_MAX};
		scrub_load_d = scrub_clamped_d ? SCB_LOAD_MAX : sm1[15:0];
		div = {2'h0, refresh_cycles} >> subpage_mode;
		ld = (div == 16'h0) ? 16'h0 : div - 16'h1;
		m = ({8'h0, rd_row_cycle} + ROW_RD_ADD > {8'h0, wr_row_cycle} + ROW_WR_ADD)
			? {8'h0, rd_row_cycle} + ROW_RD_ADD
			: {8'h0, wr_row_cycle} + ROW_WR_ADD;
		lo = ((m * 16'h5 + 16'h1) >> 1) - 16'h1;
		if (slow_mode && lo < {3'h0, REF_SLOW_MIN})
			lo = {3'h0, REF_SLOW_MIN};
		if (ld < lo)
			ld = lo;
		ref_clamped_d = ld > {3'h0, REF_LOAD_MAX};
		ref_load_d = ref_clamped_d ? REF_LOAD_MAX : ld[12:0];
	end

	// Registered results
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			scrub_load_q <= 16'h0;
			ref_load_q <= REF_LOAD_RESET;
			scrub_clamped_q <= 1'b0;
			ref_clamped_q <= 1'b0;
		end else begin
			scrub_load_q <= scrub_load_d;
			ref_load_q <= ref_load_d;
			scrub_clamped_q <= scrub_clamped_d;
			ref_clamped_q <= ref_clamped_d;
		end
	end
endmodule : mssr_load_calc
`default_nettype wire

// [verilog/mssr_maint_host.sv]
// Host sequencer that programs scrub, refresh and write-mask set-up
//
// What this block does
// - Scrub interval field holds ticks minus one
// - Scrub load never exceeds 0x80B5
// - Begin-scrub bit is written only once
// - Scrub starts only after functional reads
// - Tick load makes a 10 us tick
// - Refresh load at least 2.5 times row cycle
// - Slow mode refresh load above 103
// - Refresh load never exceeds 0x1869
// - Subpage refresh divides period by two, four
// - Keep refresh running while contents matter
`timescale 1ns/1ps
`default_nettype none
module mssr_maint_host
	import mssr_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Set-up orders
	input wire logic cfg_start,
	input wire logic [11:0] mem_clk_mhz,
	input wire logic [16:0] scrub_ticks,
	input wire logic [13:0] refresh_cycles,
	input wire logic [7:0] rd_row_cycle,
	input wire logic [7:0] wr_row_cycle,
	input wire logic slow_mode,
	input wire logic [1:0] subpage_mode,
	input wire logic write_mask_en,
	input wire logic scrub_en,
	// Run-time controls
	input wire logic functional_reads_done,
	input wire logic scrub_hold,
	input wire logic refresh_off,
	input wire logic retain_contents,
	input wire logic self_refresh,
	// Status
	output logic busy_q,
	output logic cfg_done_q,
	output logic scrub_running_q,
	output logic refresh_running_q,
	output logic scrub_clamped_q,
	output logic refresh_clamped_q,
	// Device register port
	output logic dev_wr_q,
	output logic [mssr_pkg::AW-1:0] dev_addr_q,
	output logic [mssr_pkg::DW-1:0] dev_wdata_q,
	output logic [mssr_pkg::DW-1:0] dev_wmask_q,
	input wire logic dev_ack
);
	// ------------------------------------------------------------
	// State and register declarations
	// ------------------------------------------------------------
	typedef enum logic [9:0] {
		ST_IDLE = 10'b0000000001,
		ST_TICK = 10'b0000000010,
		ST_REF = 10'b0000000100,
		ST_CFG2 = 10'b0000001000,
		ST_EXREF = 10'b0000010000,
		ST_WAITRD = 10'b0000100000,
		ST_EXSCB = 10'b0001000000,
		ST_RUN = 10'b0010000000,
		ST_HOLD = 10'b0100000000,
		ST_STOP = 10'b1000000000
	} mssr_state_t;

	mssr_state_t state_q, state_d;
	logic issued_q, issued_d;
	logic scrub_begun_q, scrub_begun_d;
	logic hold_applied_q, hold_applied_d;
	logic scrub_running_d;
	logic refresh_running_d;
	logic busy_d;
	logic cfg_done_d;
	logic [12:0] tick_load_q, tick_load_d;

	logic wr_req;
	logic [AW-1:0] wr_addr;
	logic [DW-1:0] wr_data;
	logic [DW-1:0] wr_mask;
	logic wr_done;
	logic [15:0] scrub_load;
	logic [12:0] ref_load;
	logic stop_allowed;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	mssr_load_calc u_calc (
		.clk_sys(clk_sys),
		.reset(reset),
		.scrub_ticks(scrub_ticks),
		.refresh_cycles(refresh_cycles),
		.rd_row_cycle(rd_row_cycle),
		.wr_row_cycle(wr_row_cycle),
		.slow_mode(slow_mode),
		.subpage_mode(subpage_mode),
		.scrub_load_q(scrub_load),
		.ref_load_q(ref_load),
		.scrub_clamped_q(scrub_clamped_q),
		.ref_clamped_q(refresh_clamped_q)
	);

	mssr_reg_write u_wr (
		.clk_sys(clk_sys),
		.reset(reset),
		.req(wr_req),
		.addr(wr_addr),
		.data(wr_data),
		.mask(wr_mask),
		.done_q(wr_done),
		.dev_wr_q(dev_wr_q),
		.dev_addr_q(dev_addr_q),
		.dev_wdata_q(dev_wdata_q),
		.dev_wmask_q(dev_wmask_q),
		.dev_ack(dev_ack)
	);

	// Refresh may only stop when nothing needs keeping
	assign stop_allowed = !retain_contents || self_refresh;

	// ------------------------------------------------------------
	// Tick load: the device tick is (load+1) x 4 memory clocks
	// ------------------------------------------------------------
	always_comb begin
		logic [15:0] prod;
		// 10 us x f(MHz) / 4 - 1, e.g. 1500 MHz gives 3749
		// 4095 MHz x 10 still fits the 16-bit product
		prod = ({4'h0, mem_clk_mhz} * 16'(TICK_US)) / 16'(CLK_DIV);
		if (prod == 16'h0)
			tick_load_d = 13'h0;
		else if (prod - 16'h1 > {3'h0, TICK_LOAD_MAX})
			tick_load_d = TICK_LOAD_MAX;
		else
			tick_load_d = 13'(prod - 16'h1);
	end

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	// One write per state; issued_q keeps the request to a single pulse
	always_comb begin
		state_d = state_q;
		issued_d = issued_q;
		scrub_begun_d = scrub_begun_q;
		hold_applied_d = hold_applied_q;
		scrub_running_d = scrub_running_q;
		refresh_running_d = refresh_running_q;
		cfg_done_d = 1'b0;
		wr_req = 1'b0;
		wr_addr = OFS_EXEC;
		wr_data = '0;
		wr_mask = '0;
		case (state_q)
			ST_IDLE: begin
				if (cfg_start)
					state_d = ST_TICK;
			end
			ST_TICK: begin
				wr_addr = OFS_TICK;
				wr_data = put_field({3'h0, tick_load_q}, TICK_POS, TICK_W);
				wr_mask = put_field(16'hffff, TICK_POS, TICK_W);
			end
			ST_REF: begin
				wr_addr = OFS_REFSCB;
				wr_data = put_field({3'h0, ref_load}, REF_LOAD_POS, REF_LOAD_W)
					| put_field(scrub_load, SCB_LOAD_POS, SCB_LOAD_W);
				wr_mask = put_field(16'hffff, REF_LOAD_POS, REF_LOAD_W)
					| put_field(16'hffff, SCB_LOAD_POS, SCB_LOAD_W);
			end
			ST_CFG2: begin
				wr_addr = OFS_CFG2;
				wr_data = write_mask_en ? bit_at(CFG2_WMASK_EN) : '0;
				wr_mask = bit_at(CFG2_WMASK_EN);
			end
			ST_EXREF: begin
				// Start set, block clear
				wr_data = bit_at(EXEC_REF_START);
				wr_mask = bit_at(EXEC_REF_START) | bit_at(EXEC_REF_BLOCK);
			end
			ST_WAITRD: begin
				// Scrub is begun once; later set-ups leave the bit alone
				if (!scrub_en || scrub_begun_q) begin
					state_d = ST_RUN;
					cfg_done_d = 1'b1;
				end else if (functional_reads_done) begin
					state_d = ST_EXSCB;
				end
			end
			ST_EXSCB: begin
				wr_data = bit_at(EXEC_SCB_BEGIN)
					| (scrub_hold ? bit_at(EXEC_SCB_BLOCK) : '0);
				wr_mask = bit_at(EXEC_SCB_BEGIN) | bit_at(EXEC_SCB_BLOCK);
			end
			ST_RUN: begin
				if (scrub_begun_q && scrub_hold != hold_applied_q)
					state_d = ST_HOLD;
				else if (refresh_running_q && refresh_off && stop_allowed)
					state_d = ST_STOP;
				else if (!refresh_running_q && (!refresh_off || !stop_allowed))
					state_d = ST_EXREF;
				else if (cfg_start)
					state_d = ST_TICK;
			end
			ST_HOLD: begin
				// Only the block bit is touched, never begin-scrub
				wr_data = scrub_hold ? bit_at(EXEC_SCB_BLOCK) : '0;
				wr_mask = bit_at(EXEC_SCB_BLOCK);
			end
			ST_STOP: begin
				wr_data = bit_at(EXEC_REF_BLOCK);
				wr_mask = bit_at(EXEC_REF_BLOCK);
			end
			default: begin
				state_d = ST_IDLE;
				issued_d = 1'b0;
			end
		endcase

		// Common write handshake for all writing states
		if (state_q == ST_TICK || state_q == ST_REF || state_q == ST_CFG2
			|| state_q == ST_EXREF || state_q == ST_EXSCB
			|| state_q == ST_HOLD || state_q == ST_STOP) begin
			if (!issued_q) begin
				wr_req = 1'b1;
				issued_d = 1'b1;
			end else if (wr_done) begin
				issued_d = 1'b0;
				case (state_q)
					ST_TICK: state_d = ST_REF;
					ST_REF: state_d = ST_CFG2;
					ST_CFG2: state_d = ST_EXREF;
					ST_EXREF: begin
						refresh_running_d = 1'b1;
						state_d = busy_q ? ST_WAITRD : ST_RUN;
					end
					ST_EXSCB: begin
						// Record what was written, not the live level
						scrub_begun_d = 1'b1;
						hold_applied_d = dev_wdata_q[DW-1-EXEC_SCB_BLOCK];
						scrub_running_d = !dev_wdata_q[DW-1-EXEC_SCB_BLOCK];
						state_d = ST_RUN;
						cfg_done_d = 1'b1;
					end
					ST_HOLD: begin
						hold_applied_d = dev_wdata_q[DW-1-EXEC_SCB_BLOCK];
						scrub_running_d = !dev_wdata_q[DW-1-EXEC_SCB_BLOCK];
						state_d = ST_RUN;
					end
					ST_STOP: begin
						refresh_running_d = 1'b0;
						state_d = ST_RUN;
					end
					default: state_d = ST_RUN;
				endcase
			end
		end

		// Busy covers the set-up walk only
		busy_d = state_d == ST_TICK || state_d == ST_REF
			|| state_d == ST_CFG2 || state_d == ST_WAITRD
			|| state_d == ST_EXSCB
			|| (state_d == ST_EXREF && (busy_q || state_q == ST_CFG2));
	end

	// Sequencer registers
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state_q <= ST_IDLE;
			issued_q <= 1'b0;
			scrub_begun_q <= 1'b0;
			hold_applied_q <= 1'b0;
			scrub_running_q <= 1'b0;
			refresh_running_q <= 1'b0;
			busy_q <= 1'b0;
			cfg_done_q <= 1'b0;
			tick_load_q <= 13'h0;
		end else begin
			state_q <= state_d;
			issued_q <= issued_d;
			scrub_begun_q <= scrub_begun_d;
			hold_applied_q <= hold_applied_d;
			scrub_running_q <= scrub_running_d;
			refresh_running_q <= refresh_running_d;
			busy_q <= busy_d;
			cfg_done_q <= cfg_done_d;
			tick_load_q <= tick_load_d;
		end
	end
endmodule : mssr_maint_host
`default_nettype wire

// [verilog/mssr_pkg.sv]
// Shared constants and helpers for the memory maintenance set-up controller
package mssr_pkg;

	// ------------------------------------------------------------
	// Device register window
	// ------------------------------------------------------------
	localparam int DW = 64;
	localparam int AW = 8;
	localparam logic [AW-1:0] OFS_EXEC = 8'h00;
	localparam logic [AW-1:0] OFS_REFSCB = 8'h08;
	localparam logic [AW-1:0] OFS_TICK = 8'h10;
	localparam logic [AW-1:0] OFS_CFG2 = 8'h18;

	// ------------------------------------------------------------
	// Field positions, bit 0 is the most significant bit
	// ------------------------------------------------------------
	localparam int REF_LOAD_POS = 0;
	localparam int REF_LOAD_W = 13;
	localparam int SCB_LOAD_POS = 13;
	localparam int SCB_LOAD_W = 16;
	localparam int TICK_POS = 0;
	localparam int TICK_W = 13;
	localparam int EXEC_REF_START = 1;
	localparam int EXEC_SCB_BEGIN = 2;
	localparam int EXEC_REF_BLOCK = 3;
	localparam int EXEC_SCB_BLOCK = 4;
	localparam int CFG2_WMASK_EN = 3;

	// ------------------------------------------------------------
	// Load limits and timing figures
	// ------------------------------------------------------------
	localparam logic [15:0] SCB_LOAD_MAX = 16'h80b5;
	localparam logic [12:0] REF_LOAD_RESET = 13'h200;
	localparam logic [12:0] REF_LOAD_MAX = 13'h1869;
	localparam logic [12:0] REF_SLOW_MIN = 13'h0068;
	localparam logic [15:0] ROW_RD_ADD = 16'h0004;
	localparam logic [15:0] ROW_WR_ADD = 16'h0001;
	localparam int TICK_US = 10;
	localparam int CLK_DIV = 4;
	localparam logic [12:0] TICK_LOAD_MAX = 13'h1fff;

	// Field value placed at its big-endian position
	function automatic logic [DW-1:0] put_field(input logic [15:0] v,
		input int pos, input int w);
		logic [DW-1:0] m;
		m = ({{(DW-16){1'b0}}, v}) & ((64'h1 << w) - 64'h1);
		put_field = m << (DW - pos - w);
	endfunction : put_field

	// Single bit at its big-endian position
	function automatic logic [DW-1:0] bit_at(input int pos);
		bit_at = 64'h1 << (DW - 1 - pos);
	endfunction : bit_at

endpackage : mssr_pkg

// [verilog/mssr_reg_write.sv]
// Masked register write port toward the device
`timescale 1ns/1ps
`default_nettype none
module mssr_reg_write
	import mssr_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Request from the sequencer
	input wire logic req,
	input wire logic [mssr_pkg::AW-1:0] addr,
	input wire logic [mssr_pkg::DW-1:0] data,
	input wire logic [mssr_pkg::DW-1:0] mask,
	output logic done_q,
	// Device register port
	output logic dev_wr_q,
	output logic [mssr_pkg::AW-1:0] dev_addr_q,
	output logic [mssr_pkg::DW-1:0] dev_wdata_q,
	output logic [mssr_pkg::DW-1:0] dev_wmask_q,
	input wire logic dev_ack
);
	logic dev_wr_d;
	logic done_d;
	logic [AW-1:0] dev_addr_d;
	logic [DW-1:0] dev_wdata_d;
	logic [DW-1:0] dev_wmask_d;

	// Hold the write until acknowledged; mask keeps other bits untouched
	always_comb begin
		dev_wr_d = dev_wr_q;
		dev_addr_d = dev_addr_q;
		dev_wdata_d = dev_wdata_q;
		dev_wmask_d = dev_wmask_q;
		done_d = 1'b0;
		if (dev_wr_q) begin
			if (dev_ack) begin
				dev_wr_d = 1'b0;
				done_d = 1'b1;
			end
		end else if (req) begin
			dev_wr_d = 1'b1;
			dev_addr_d = addr;
			dev_wdata_d = data & mask;
			dev_wmask_d = mask;
		end
	end

	// Port registers
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			dev_wr_q <= 1'b0;
			dev_addr_q <= '0;
			dev_wdata_q <= '0;
			dev_wmask_q <= '0;
			done_q <= 1'b0;
		end else begin
			dev_wr_q <= dev_wr_d;
			dev_addr_q <= dev_addr_d;
			dev_wdata_q <= dev_wdata_d;
			dev_wmask_q <= dev_wmask_d;
			done_q <= done_d;
		end
	end
endmodule : mssr_reg_write
`default_nettype wire
